// ===== rtl/ebr_pkg.sv
// Summary of operation
// - Each port F pin taken from the bus is individually input or output.
// - After reset the shared data pins belong to the external data bus.
// - Clearing port F pull-up enable bit n turns off pin n pull-up.
// - The read strobe is asserted during every external memory read cycle.
// - While read strobe is low all sixteen data pins are inputs, except port F pins selected as outputs.
// - On the strobe's rising edge the data pins are captured internally.
// - Asserted read strobe qualifies address, program, data and chip selects.
// - The idle bus drive bit chooses tri-state or driven idle strobe.
// - Software should set the idle bus drive bit to one.
// - The control pull-up disable bit switches off the strobe pin pull-up.
package ebr_pkg;
	localparam int EBR_DATA_W = 16;
	localparam int EBR_ADDR_W = 24;
	localparam int EBR_PORT_W = 8;
	localparam int EBR_REG_AW = 4;
	localparam logic [3:0] EBR_OFS_BUS_CTRL = 4'h0;
	localparam logic [3:0] EBR_OFS_SYS_PUD = 4'h1;
	localparam logic [3:0] EBR_OFS_PF_PUR = 4'h2;
	localparam logic [3:0] EBR_OFS_PF_SEL = 4'h3;
	localparam logic [3:0] EBR_OFS_PF_DIR = 4'h4;
	localparam logic [3:0] EBR_OFS_PF_OUT = 4'h5;
	localparam logic [3:0] EBR_OFS_PF_IN = 4'h6;
	localparam logic [3:0] EBR_OFS_RD_DATA = 4'h7;
	localparam logic [3:0] EBR_OFS_STATUS = 4'h8;
	localparam int EBR_BIT_DRV = 0;
	localparam int EBR_BIT_CTRL_PUD = 0;
	localparam logic [15:0] EBR_RST_BUS_CTRL = 16'h0000;
	localparam logic [15:0] EBR_RST_SYS_PUD = 16'h0000;
	localparam logic [7:0] EBR_RST_PF_PUR = 8'hff;
	localparam logic [7:0] EBR_RST_PF_SEL = 8'h00;
	localparam logic [7:0] EBR_RST_PF_DIR = 8'h00;
	localparam logic [7:0] EBR_RST_PF_OUT = 8'h00;
	localparam int EBR_RD_WAIT = 2;
	typedef enum logic [1:0] {
		EBR_IDLE,
		EBR_STROBE,
		EBR_DONE
	} ebr_state_t;
	typedef struct packed {
		logic [EBR_REG_AW-1:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ebr_reg_req_t;
	typedef struct packed {
		logic [EBR_ADDR_W-1:0] addr;
		logic prog_space;
		logic [1:0] chip_sel;
	} ebr_mem_req_t;
	typedef struct packed {
		logic strobe_o;
		logic strobe_oe;
		logic strobe_pu;
	} ebr_strobe_pin_t;
endpackage : ebr_pkg

// ===== rtl/ebr_port_f.sv
`timescale 1ns/10ps
module ebr_port_f
	import ebr_pkg::*;
#(
	parameter int W = EBR_PORT_W
) (
	input wire logic [W-1:0] sel_gpio,
	input wire logic [W-1:0] dir_out,
	input wire logic [W-1:0] out_val,
	input wire logic [W-1:0] pur,
	input wire logic bus_oe,
	input wire logic [W-1:0] bus_out,
	output logic [W-1:0] pin_o,
	output logic [W-1:0] pin_oe,
	output logic [W-1:0] pin_pu
);
	// Pins are handed to the bus or to the port one at a time.
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (sel_gpio[i]) begin
				pin_o[i] = out_val[i];
				pin_oe[i] = dir_out[i];
			end else begin
				pin_o[i] = bus_out[i];
				pin_oe[i] = bus_oe;
			end
			pin_pu[i] = pur[i] & ~pin_oe[i];
		end
	end
endmodule : ebr_port_f

// ===== rtl/ebr_read_strobe.sv
`timescale 1ns/10ps
module ebr_read_strobe
	import ebr_pkg::*;
#(
	parameter int RD_WAIT = EBR_RD_WAIT
) (
	input wire logic clk,
	input wire logic nrst,
	input ebr_reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	input wire logic rd_start,
	input ebr_mem_req_t rd_req,
	output logic rd_busy,
	output logic rd_done,
	output logic [EBR_ADDR_W-1:0] addr_o,
	output logic addr_oe,
	output logic program_space_select_n,
	output logic data_space_select_n,
	output logic [1:0] chip_select_n,
	output logic selects_oe,
	output ebr_strobe_pin_t rd_strobe_pin,
	input wire logic [EBR_DATA_W-1:0] data_i,
	output logic [7:0] data_low_oe,
	output logic [EBR_PORT_W-1:0] port_f_general_pins_o,
	output logic [EBR_PORT_W-1:0] port_f_general_pins_oe,
	output logic [EBR_PORT_W-1:0] port_f_general_pins_pu
);
	ebr_state_t state;
	ebr_state_t next_state;
	logic [15:0] ext_bus_control_reg;
	logic [15:0] next_ext_bus_control_reg;
	logic [15:0] system_pullup_disable_reg;
	logic [15:0] next_system_pullup_disable_reg;
	logic [EBR_PORT_W-1:0] port_f_pullup_enable_reg;
	logic [EBR_PORT_W-1:0] next_port_f_pullup_enable_reg;
	logic [EBR_PORT_W-1:0] pf_sel;
	logic [EBR_PORT_W-1:0] next_pf_sel;
	logic [EBR_PORT_W-1:0] pf_dir;
	logic [EBR_PORT_W-1:0] next_pf_dir;
	logic [EBR_PORT_W-1:0] pf_out;
	logic [EBR_PORT_W-1:0] next_pf_out;
	logic [EBR_DATA_W-1:0] rd_data;
	logic [EBR_DATA_W-1:0] next_rd_data;
	ebr_mem_req_t cur;
	ebr_mem_req_t next_cur;
	logic [3:0] wait_cnt;
	logic [3:0] next_wait_cnt;
	logic [15:0] next_reg_rdata;
	logic idle_drive;
	logic strobe_low;

	function automatic logic reg_hit(input ebr_reg_req_t r,
		input logic [3:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction : reg_hit

	assign idle_drive = ext_bus_control_reg[EBR_BIT_DRV];
	assign strobe_low = (state == EBR_STROBE);
	assign rd_busy = (state != EBR_IDLE);
	assign rd_done = (state == EBR_DONE);

	always_comb begin
		next_state = state;
		next_cur = cur;
		next_wait_cnt = wait_cnt;
		next_rd_data = rd_data;
		case (state)
			EBR_IDLE: begin
				if (rd_start) begin
					next_cur = rd_req;
					next_wait_cnt = 4'(RD_WAIT);
					next_state = EBR_STROBE;
				end
			end
			EBR_STROBE: begin
				if (wait_cnt > 4'h1) begin
					next_wait_cnt = wait_cnt - 4'h1;
				end else begin
					// Capture coincides with the strobe's rising edge.
					next_rd_data = data_i;
					next_state = EBR_DONE;
				end
			end
			EBR_DONE: begin
				next_state = EBR_IDLE;
			end
			default: begin
				next_state = EBR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= EBR_IDLE;
			cur <= '0;
			wait_cnt <= 4'h0;
			rd_data <= 16'h0000;
		end else begin
			state <= next_state;
			cur <= next_cur;
			wait_cnt <= next_wait_cnt;
			rd_data <= next_rd_data;
		end
	end

	// Register file over the plain port.
	always_comb begin
		next_ext_bus_control_reg = ext_bus_control_reg;
		next_system_pullup_disable_reg = system_pullup_disable_reg;
		next_port_f_pullup_enable_reg = port_f_pullup_enable_reg;
		next_pf_sel = pf_sel;
		next_pf_dir = pf_dir;
		next_pf_out = pf_out;
		if (reg_hit(reg_req, EBR_OFS_BUS_CTRL)) begin
			next_ext_bus_control_reg = reg_req.wdata;
		end
		if (reg_hit(reg_req, EBR_OFS_SYS_PUD)) begin
			next_system_pullup_disable_reg = reg_req.wdata;
		end
		if (reg_hit(reg_req, EBR_OFS_PF_PUR)) begin
			next_port_f_pullup_enable_reg = reg_req.wdata[7:0];
		end
		if (reg_hit(reg_req, EBR_OFS_PF_SEL)) begin
			next_pf_sel = reg_req.wdata[7:0];
		end
		if (reg_hit(reg_req, EBR_OFS_PF_DIR)) begin
			next_pf_dir = reg_req.wdata[7:0];
		end
		if (reg_hit(reg_req, EBR_OFS_PF_OUT)) begin
			next_pf_out = reg_req.wdata[7:0];
		end
		next_reg_rdata = 16'h0000;
		if (reg_req.rd) begin
			case (reg_req.addr)
				EBR_OFS_BUS_CTRL: next_reg_rdata = ext_bus_control_reg;
				EBR_OFS_SYS_PUD: next_reg_rdata = system_pullup_disable_reg;
				EBR_OFS_PF_PUR: next_reg_rdata = {8'h00,
					port_f_pullup_enable_reg};
				EBR_OFS_PF_SEL: next_reg_rdata = {8'h00, pf_sel};
				EBR_OFS_PF_DIR: next_reg_rdata = {8'h00, pf_dir};
				EBR_OFS_PF_OUT: next_reg_rdata = {8'h00, pf_out};
				EBR_OFS_PF_IN: next_reg_rdata = {8'h00, data_i[15:8]};
				EBR_OFS_RD_DATA: next_reg_rdata = rd_data;
				EBR_OFS_STATUS: next_reg_rdata = {15'h0000, rd_busy};
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_bus_control_reg <= EBR_RST_BUS_CTRL;
			system_pullup_disable_reg <= EBR_RST_SYS_PUD;
			port_f_pullup_enable_reg <= EBR_RST_PF_PUR;
			pf_sel <= EBR_RST_PF_SEL;
			pf_dir <= EBR_RST_PF_DIR;
			pf_out <= EBR_RST_PF_OUT;
			reg_rdata <= 16'h0000;
		end else begin
			ext_bus_control_reg <= next_ext_bus_control_reg;
			system_pullup_disable_reg <= next_system_pullup_disable_reg;
			port_f_pullup_enable_reg <= next_port_f_pullup_enable_reg;
			pf_sel <= next_pf_sel;
			pf_dir <= next_pf_dir;
			pf_out <= next_pf_out;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Strobe pin. Reset clears state asynchronously, so the driver is off
	// and the pull-up on for as long as nrst is low.
	always_comb begin
		rd_strobe_pin.strobe_o = ~strobe_low;
		rd_strobe_pin.strobe_oe = nrst && (strobe_low || idle_drive);
		rd_strobe_pin.strobe_pu = (~nrst) ||
			(~system_pullup_disable_reg[EBR_BIT_CTRL_PUD] &&
			~rd_strobe_pin.strobe_oe);
	end

	// Selects are asserted only while the strobe is low; they are held
	// inactive when driven idle so a memory never sees a stale select.
	always_comb begin
		addr_o = cur.addr;
		addr_oe = strobe_low || idle_drive;
		program_space_select_n = ~(strobe_low && cur.prog_space);
		data_space_select_n = ~(strobe_low && ~cur.prog_space);
		chip_select_n = ~({2{strobe_low}} & cur.chip_sel);
		selects_oe = strobe_low || idle_drive;
	end

	// Reads never drive the bus: the memory uses the strobe as its enable.
	assign data_low_oe = 8'h00;

	ebr_port_f #(
		.W(EBR_PORT_W)
	) u_port_f (
		.sel_gpio(pf_sel),
		.dir_out(pf_dir),
		.out_val(pf_out),
		.pur(port_f_pullup_enable_reg),
		.bus_oe(1'b0),
		.bus_out(8'h00),
		.pin_o(port_f_general_pins_o),
		.pin_oe(port_f_general_pins_oe),
		.pin_pu(port_f_general_pins_pu)
	);
endmodule : ebr_read_strobe

// ===== dv/ebr_asserts.sv
`timescale 1ns/10ps
module ebr_asserts
	import ebr_pkg::*;
#(
	parameter int RD_WAIT = EBR_RD_WAIT
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic rd_start,
	input wire logic rd_busy,
	input wire logic rd_done,
	input wire logic [EBR_ADDR_W-1:0] addr_o,
	input wire logic addr_oe,
	input wire logic program_space_select_n,
	input wire logic data_space_select_n,
	input wire logic selects_oe,
	input ebr_strobe_pin_t rd_strobe_pin,
	input wire logic [7:0] data_low_oe
);
	wire logic s = rd_strobe_pin.strobe_o;
	int low_cnt;
	int next_low_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	always_comb next_low_cnt = s ? 0 : low_cnt + 1;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			low_cnt <= 0;
		else
			low_cnt <= next_low_cnt;
	end
	a_strobe_start: assert property (rd_start && !rd_busy |=> !s)
		else $error("strobe did not fall");
	a_strobe_len: assert property ($rose(s) |-> low_cnt == RD_WAIT)
		else $error("strobe low time wrong");
	a_done_rise: assert property (rd_done == $rose(s))
		else $error("done not at strobe rise");
	a_data_input: assert property (!s |-> data_low_oe == 8'h00)
		else $error("data driven in read");
	a_sel_qual: assert property (!s |-> selects_oe && addr_oe &&
		program_space_select_n != data_space_select_n)
		else $error("selects not qualified");
	a_sel_idle: assert property (s |-> program_space_select_n &&
		data_space_select_n) else $error("select low while idle");
	a_addr_hold: assert property (!s && !$past(s) |-> $stable(addr_o))
		else $error("address moved in read");
	a_strobe_drv: assert property (!s |-> rd_strobe_pin.strobe_oe &&
		!rd_strobe_pin.strobe_pu) else $error("strobe not driven");
endmodule : ebr_asserts
bind ebr_read_strobe ebr_asserts #(.RD_WAIT(RD_WAIT)) u_chk (.clk, .nrst,
	.rd_start, .rd_busy, .rd_done, .addr_o, .addr_oe, .program_space_select_n,
	.data_space_select_n, .selects_oe, .rd_strobe_pin, .data_low_oe);

// ===== dv/ebr_sram_model.sv
`timescale 1ns/10ps
module ebr_sram_model (
	input wire logic clk,
	input wire logic oe_n,
	input wire logic slow,
	input wire logic [15:0] addr,
	output logic [15:0] dq
);
	logic [15:0] last = 16'h0000;
	logic was_off = 1'b1;
	always_ff @(posedge clk) begin
		was_off <= oe_n;
		last <= dq;
	end
	// A slow part shows garbage in the first strobe cycle.
	always_comb begin
		if (!oe_n && !(slow && was_off))
			dq = addr ^ 16'h5a3c;
		else
			dq = ~last;
	end
endmodule : ebr_sram_model

// ===== dv/test_ext_bus_read_strobe_data_pins.sv
`timescale 1ns/10ps
module test_ext_bus_read_strobe_data_pins
	import ebr_pkg::*;
;
	logic clk = 0;
	logic nrst = 0;
	logic rd_start = 0;
	logic slow = 0;
	ebr_reg_req_t reg_req = '0;
	ebr_mem_req_t rd_req = '0;
	ebr_strobe_pin_t pin;
	logic [15:0] reg_rdata, dq, data_i;
	logic rd_busy, rd_done, addr_oe, ps_n, ds_n, sel_oe;
	logic [1:0] cs_n;
	logic [23:0] addr_o;
	logic [7:0] dlo_oe, pf_o, pf_oe, pf_pu;
	int error_cnt = 0;
	int samples_checked = 0;
	assign data_i = {(pf_oe & pf_o) | (~pf_oe & dq[15:8]), dq[7:0]};
	ebr_read_strobe dut_u (.clk, .nrst, .reg_req, .reg_rdata, .rd_start,
		.rd_req, .rd_busy, .rd_done, .addr_o, .addr_oe,
		.program_space_select_n(ps_n), .data_space_select_n(ds_n),
		.chip_select_n(cs_n), .selects_oe(sel_oe), .rd_strobe_pin(pin),
		.data_i, .data_low_oe(dlo_oe), .port_f_general_pins_o(pf_o),
		.port_f_general_pins_oe(pf_oe), .port_f_general_pins_pu(pf_pu));
	ebr_sram_model mem_u (.clk, .oe_n(pin.strobe_o | ~pin.strobe_oe),
		.slow, .addr(addr_o[15:0]), .dq);
	initial forever #50 clk = ~clk;
	initial begin
		#100000;
		error_cnt++;
		end_sim();
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		reg_req.wr <= 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		reg_req.rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask : rd
	task automatic t_idle;
		chk(pin, 3'b101);
		wr(EBR_OFS_SYS_PUD, 16'h0001);
		chk(pin, 3'b100);
		wr(EBR_OFS_BUS_CTRL, 16'h0001);
		chk(pin, 3'b110);
	endtask : t_idle
	task automatic t_port;
		rd(EBR_OFS_PF_SEL, 16'h0000);
		wr(EBR_OFS_PF_SEL, 16'h00ff);
		wr(EBR_OFS_PF_DIR, 16'h000f);
		wr(EBR_OFS_PF_OUT, 16'h00a5);
		wr(EBR_OFS_PF_PUR, 16'h00fe);
		chk({pf_oe, pf_o & pf_oe, pf_pu}, 24'h0f05f0);
		wr(EBR_OFS_PF_DIR, 16'h0000);
		chk(pf_pu, 8'hfe);
		wr(EBR_OFS_PF_SEL, 16'h0000);
	endtask : t_port
	// The start is held one extra cycle so the busy refusal is exercised.
	task automatic t_read(input logic s, input logic [23:0] a, input logic ps);
		int i;
		@(posedge clk);
		slow <= s;
		rd_req <= '{a, ps, 2'b01};
		rd_start <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk({pin.strobe_o, ps_n, ds_n, pf_oe}, {1'b0, ~ps, ps, 8'h00});
		chk({cs_n, addr_oe, sel_oe, rd_busy}, {2'b10, 3'b111});
		chk(addr_o, a);
		@(posedge clk);
		rd_start <= 1'b0;
		i = 0;
		while (rd_done !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		chk(rd_done, 1'b1);
		rd(EBR_OFS_RD_DATA, a[15:0] ^ 16'h5a3c);
		rd(EBR_OFS_STATUS, 16'h0000);
	endtask : t_read
	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		repeat (10) @(posedge clk);
		chk({pin, pf_oe, pf_pu}, {3'b101, 16'h00ff});
		nrst <= 1'b1;
		t_idle();
		t_port();
		t_read(1'b0, 24'h001234, 1'b1);
		t_read(1'b1, 24'h0afe01, 1'b0);
		end_sim();
	end
endmodule : test_ext_bus_read_strobe_data_pins
